// [inc/tss_regs.svh]
// register map, codes, field positions and timing constants
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH
// byte addresses
`define TSS_ADR_SRC       8'h00
`define TSS_ADR_PAT       8'h04
`define TSS_ADR_PER       8'h08
`define TSS_ADR_SETUP     8'h0c
`define TSS_ADR_LINES     8'h10
`define TSS_ADR_COUNT     8'h14
`define TSS_ADR_DELAY     8'h18
`define TSS_ADR_SAMP      8'h1c
`define TSS_ADR_CMD       8'h20
`define TSS_ADR_STAT      8'h24
// source and line codes
`define TSS_SRC_IMM       5'h00
`define TSS_SRC_PAT       5'h01
`define TSS_SRC_POS0      5'h02
`define TSS_SRC_NEG0      5'h0a
`define TSS_SRC_MAX       5'h11
`define TSS_LINE_NONE     4'h8
// reset values
`define TSS_RST_COUNT     31'h0000_0001
`define TSS_RST_PER       32'h0000_0000
// field positions
`define TSS_PAT_ARM_TMR   24
`define TSS_LN_OUT_LSB    0
`define TSS_LN_IN_LSB     8
`define TSS_LN_CFG_LSB    16
`define TSS_CMD_INIT      0
`define TSS_CMD_SOFT      1
`define TSS_CMD_ARM       2
`define TSS_ST_ILL        4
`define TSS_ST_REJ        5
// timing
`define TSS_CLK_HZ        125000000
`define TSS_US_PER_S      1000000
`define TSS_US_CYC        (`TSS_CLK_HZ / `TSS_US_PER_S)
`define TSS_SETUP_MAX_S   167
`define TSS_SETUP_MAX_US  (`TSS_SETUP_MAX_S * `TSS_US_PER_S)
`endif

// [inc/tss_pkg.sv]
// types shared by the trigger source select block
package tss_pkg;
    typedef enum logic [2:0] {
        TSS_IDLE = 3'h0,
        TSS_INIT = 3'h1,
        TSS_ARM  = 3'h2,
        TSS_TRIG = 3'h3,
        TSS_DLY  = 3'h4
    } tss_state_t;

    // pattern trigger mask, bus lines in the low byte
    typedef struct packed {
        logic       sw;
        logic       tmr;
        logic [7:0] dio;
        logic [7:0] bus;
    } tss_pat_t;
endpackage

// [src/tss_top.sv]
// trigger source select with trigger layer sequencer and wishbone registers
//
// Function
// - source select holds codes 0..17, resets to immediate 0.
// - immediate source skips trigger layer after arm, acquisition starts.
// - pattern code 1 combines bus, dio, timer and software events.
// - codes 2..9 trigger on rising edge of bus line 0..7.
// - codes 10..17 trigger on falling edge of bus line 0..7.
// - timer setup selects pattern, timer only, period up to 167 s.
// - output and input line selectors, 0..7 line, 8 none, reset 8.
// - combined events go out on one reserved line, read back from the selected input line.
// - master drives events on output line only when configured as output.
// - master takes own events from input line, may differ from output.
// - timer period 0 to 4294.967295 s in microseconds, resets zero.
// - timer never enabled as arm and trigger source at once.
// - timer chosen only through pattern masks, no dedicated code.
// - trigger count 1..2^31-1, zero unlimited, resets to 1.
// - trigger delay rounded to whole sample periods.
// - software trigger only legal with pattern source, else flagged.
// - initiate command moves idle layer to init layer.
//
// Implementation choices: register access over Wishbone and the address map.
`include "tss_regs.svh"
module tss_top #(
    parameter logic [31:0] SAMP_PERIOD_US = 32'h0000_03e8
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // trigger bus pins
    input  wire logic [7:0]  trig_bus_i,
    output logic      [7:0]  trig_bus_o,
    output logic      [7:0]  trig_bus_oe_o,
    // other event sources
    input  wire logic [7:0]  dio_i,
    input  wire logic        arm_evt_i,
    // sequencer outputs
    output logic             trig_evt_o,
    output logic             acq_start_o,
    output logic      [2:0]  state_o
);
    localparam int NIN = 16;

    tss_pkg::tss_state_t state_r;
    tss_pkg::tss_pat_t   pat_r;
    tss_pkg::tss_pat_t   pat_nxt;
    logic [4:0]          trig_src_sel_r;
    logic                arm_tmr_r;
    logic [31:0]         timer_src_period_r;
    logic [3:0]          combined_evt_out_line_r;
    logic [3:0]          combined_evt_in_line_r;
    logic [7:0]          bus_cfg_r;
    logic [30:0]         trig_repeat_count_r;
    logic [31:0]         dly_r;
    logic [31:0]         samp_r;
    logic                soft_ill_r;
    logic                cfg_rej_r;
    logic                ack_r;
    logic [31:0]         dat_r;
    logic [NIN-1:0]      s1_r;
    logic [NIN-1:0]      s2_r;
    logic [NIN-1:0]      s3_r;
    logic [NIN-1:0]      lvl_r;
    logic [NIN-1:0]      rise;
    logic [NIN-1:0]      fall;
    logic [7:0]          pre_r;
    logic [31:0]         tmr_cnt_r;
    logic                tmr_evt_r;
    logic [31:0]         smp_cnt_r;
    logic                comb_evt_r;
    logic                comb_d1_r;
    logic [7:0]          bus_o_r;
    logic [7:0]          bus_oe_r;
    logic [30:0]         rem_r;
    logic [34:0]         acc_r;
    logic                trg_r;
    logic                acq_r;

    // bus decode
    logic [7:0]  adr;
    logic        req;
    logic        wr;
    logic [31:0] wmask;
    logic [31:0] wd;
    assign adr   = {wb_adr_i[7:2], 2'h0};
    assign req   = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr    = req & wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wd    = wb_dat_i & wmask;

    logic cmd_wr;
    logic cmd_init;
    logic cmd_soft;
    logic cmd_arm;
    assign cmd_wr   = wr & (adr == `TSS_ADR_CMD);
    assign cmd_init = cmd_wr & wd[`TSS_CMD_INIT];
    assign cmd_soft = cmd_wr & wd[`TSS_CMD_SOFT];
    assign cmd_arm  = cmd_wr & wd[`TSS_CMD_ARM];

    // configuration writes that would break the source rules
    logic rej_src;
    logic rej_pat;
    logic rej_setup;
    logic rej;
    assign pat_nxt   = tss_pkg::tss_pat_t'(wd[17:0]);
    assign rej_src   = (adr == `TSS_ADR_SRC) &
                       (wd > {27'h0, `TSS_SRC_MAX});
    assign rej_pat   = (adr == `TSS_ADR_PAT) & pat_nxt.tmr &
                       wd[`TSS_PAT_ARM_TMR];
    assign rej_setup = (adr == `TSS_ADR_SETUP) &
                       ((wd > 32'(`TSS_SETUP_MAX_US)) | arm_tmr_r);
    assign rej       = wr & (rej_src | rej_pat | rej_setup);

    // wishbone answer: one cycle after the request, unmapped reads zero
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= req;
            if (req) begin
                case (adr)
                    `TSS_ADR_SRC:   dat_r <= {27'h0, trig_src_sel_r};
                    `TSS_ADR_PAT:   dat_r <= {7'h0, arm_tmr_r, 6'h0, pat_r};
                    `TSS_ADR_PER:   dat_r <= timer_src_period_r;
                    `TSS_ADR_LINES: dat_r <= {8'h0, bus_cfg_r, 4'h0,
                                              combined_evt_in_line_r, 4'h0,
                                              combined_evt_out_line_r};
                    `TSS_ADR_COUNT: dat_r <= {1'b0, trig_repeat_count_r};
                    `TSS_ADR_DELAY: dat_r <= dly_r;
                    `TSS_ADR_SAMP:  dat_r <= samp_r;
                    `TSS_ADR_STAT:  dat_r <= {26'h0, cfg_rej_r, soft_ill_r,
                                              1'b0, state_r};
                    default:        dat_r <= 32'h0;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // configuration registers
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            trig_src_sel_r          <= `TSS_SRC_IMM;
            pat_r                   <= '0;
            arm_tmr_r               <= 1'b0;
            timer_src_period_r      <= `TSS_RST_PER;
            combined_evt_out_line_r <= `TSS_LINE_NONE;
            combined_evt_in_line_r  <= `TSS_LINE_NONE;
            bus_cfg_r               <= 8'h0;
            trig_repeat_count_r     <= `TSS_RST_COUNT;
            dly_r                   <= 32'h0;
            samp_r                  <= SAMP_PERIOD_US;
        end else if (wr && !rej) begin
            case (adr)
                `TSS_ADR_SRC:   trig_src_sel_r <= wd[4:0];
                `TSS_ADR_PAT: begin
                    pat_r     <= pat_nxt;
                    arm_tmr_r <= wd[`TSS_PAT_ARM_TMR];
                end
                `TSS_ADR_PER:   timer_src_period_r <= wd;
                `TSS_ADR_SETUP: begin
                    trig_src_sel_r     <= `TSS_SRC_PAT;
                    pat_r              <= '{sw: 1'b0, tmr: 1'b1,
                                            dio: 8'h0, bus: 8'h0};
                    timer_src_period_r <= wd;
                end
                `TSS_ADR_LINES: begin
                    if (wd[`TSS_LN_OUT_LSB+:4] <= `TSS_LINE_NONE) begin
                        combined_evt_out_line_r <= wd[`TSS_LN_OUT_LSB+:4];
                    end
                    if (wd[`TSS_LN_IN_LSB+:4] <= `TSS_LINE_NONE) begin
                        combined_evt_in_line_r <= wd[`TSS_LN_IN_LSB+:4];
                    end
                    bus_cfg_r <= wd[`TSS_LN_CFG_LSB+:8];
                end
                `TSS_ADR_COUNT: trig_repeat_count_r <= wd[30:0];
                `TSS_ADR_DELAY: dly_r <= wd;
                `TSS_ADR_SAMP: begin
                    if (wd != 32'h0) begin
                        samp_r <= wd;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // sticky error flags, write one to clear, a new event wins
    logic src_is_pat;
    logic stat_wr;
    assign src_is_pat = (trig_src_sel_r == `TSS_SRC_PAT);
    assign stat_wr    = wr & (adr == `TSS_ADR_STAT);
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            soft_ill_r <= 1'b0;
            cfg_rej_r  <= 1'b0;
        end else begin
            if (cmd_soft && !src_is_pat) begin
                soft_ill_r <= 1'b1;
            end else if (stat_wr && wd[`TSS_ST_ILL]) begin
                soft_ill_r <= 1'b0;
            end
            if (rej) begin
                cfg_rej_r <= 1'b1;
            end else if (stat_wr && wd[`TSS_ST_REJ]) begin
                cfg_rej_r <= 1'b0;
            end
        end
    end

    // pin synchronisers and edge detect, bus lines low, dio high
    logic [NIN-1:0] pins;
    assign pins = {dio_i, trig_bus_i};
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge core_clk_i) begin
                if (!resetn_i) begin
                    s1_r[gi]  <= 1'b0;
                    s2_r[gi]  <= 1'b0;
                    s3_r[gi]  <= 1'b0;
                    lvl_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pins[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        lvl_r[gi] <= s3_r[gi];
                    end
                end
            end
            assign rise[gi] = (s2_r[gi] == s3_r[gi]) & s3_r[gi] &
                              ~lvl_r[gi];
            assign fall[gi] = (s2_r[gi] == s3_r[gi]) & ~s3_r[gi] &
                              lvl_r[gi];
        end
    endgenerate

    // microsecond prescaler, trigger timer and sample clock
    logic us_tick;
    logic per_wr;
    assign us_tick = (pre_r == 8'(`TSS_US_CYC - 1));
    assign per_wr  = wr & ((adr == `TSS_ADR_PER) | (adr == `TSS_ADR_SETUP));
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pre_r <= 8'h0;
        end else begin
            pre_r <= us_tick ? 8'h0 : pre_r + 8'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            tmr_cnt_r <= 32'h0;
            tmr_evt_r <= 1'b0;
        end else begin
            tmr_evt_r <= 1'b0;
            if (per_wr || timer_src_period_r == 32'h0) begin
                tmr_cnt_r <= 32'h0;
            end else if (us_tick) begin
                if (tmr_cnt_r == timer_src_period_r - 32'h1) begin
                    tmr_cnt_r <= 32'h0;
                    tmr_evt_r <= 1'b1;
                end else begin
                    tmr_cnt_r <= tmr_cnt_r + 32'h1;
                end
            end
        end
    end

    logic smp_tick;
    assign smp_tick = us_tick & (smp_cnt_r >= samp_r - 32'h1);
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            smp_cnt_r <= 32'h0;
        end else if (us_tick) begin
            smp_cnt_r <= smp_tick ? 32'h0 : smp_cnt_r + 32'h1;
        end
    end

    // combined pattern event, held two cycles on the pin so that
    // a three-stage synchroniser reading it back still sees it
    logic pat_evt;
    logic ret_evt;
    assign pat_evt = |(pat_r.bus & rise[7:0]) | |(pat_r.dio & rise[15:8]) |
                     (pat_r.tmr & tmr_evt_r) |
                     (pat_r.sw & cmd_soft & src_is_pat);
    assign ret_evt = (combined_evt_in_line_r == `TSS_LINE_NONE) ?
                     comb_evt_r :
                     rise[combined_evt_in_line_r[2:0]];
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            comb_evt_r <= 1'b0;
            comb_d1_r  <= 1'b0;
            bus_o_r    <= 8'h0;
            bus_oe_r   <= 8'h0;
        end else begin
            comb_evt_r <= pat_evt;
            comb_d1_r  <= comb_evt_r;
            for (int i = 0; i < 8; i++) begin
                bus_oe_r[i] <= bus_cfg_r[i] &
                    (combined_evt_out_line_r == 4'(i));
                bus_o_r[i]  <= bus_cfg_r[i] & (comb_evt_r | comb_d1_r) &
                    (combined_evt_out_line_r == 4'(i));
            end
        end
    end
    assign trig_bus_o    = bus_o_r;
    assign trig_bus_oe_o = bus_oe_r;

    // trigger selection
    logic [4:0] pos_idx;
    logic [4:0] neg_idx;
    logic       trig_hit;
    assign pos_idx = trig_src_sel_r - `TSS_SRC_POS0;
    assign neg_idx = trig_src_sel_r - `TSS_SRC_NEG0;
    always_comb begin
        trig_hit = 1'b0;
        if (src_is_pat) begin
            trig_hit = ret_evt;
        end else if (trig_src_sel_r >= `TSS_SRC_NEG0) begin
            trig_hit = fall[neg_idx[2:0]];
        end else if (trig_src_sel_r >= `TSS_SRC_POS0) begin
            trig_hit = rise[pos_idx[2:0]];
        end
    end

    // rounded half up: start once 2*acc > 2*delay - period
    logic [34:0] dly2;
    logic [34:0] smp35;
    logic [34:0] tgt;
    logic        arm_evt;
    logic        last;
    assign dly2    = {2'h0, dly_r, 1'b0};
    assign smp35   = {3'h0, samp_r};
    assign tgt     = (dly2 >= smp35) ? dly2 - smp35 + 35'h1 :
                     35'h0;
    assign arm_evt = arm_evt_i | cmd_arm | (arm_tmr_r & tmr_evt_r);
    assign last    = (trig_repeat_count_r != 31'h0) && (rem_r <= 31'h1);

    // trigger state machine
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_r <= tss_pkg::TSS_IDLE;
            rem_r   <= `TSS_RST_COUNT;
            acc_r   <= 35'h0;
            trg_r   <= 1'b0;
            acq_r   <= 1'b0;
        end else begin
            trg_r <= 1'b0;
            acq_r <= 1'b0;
            case (state_r)
                tss_pkg::TSS_IDLE: begin
                    if (cmd_init) begin
                        state_r <= tss_pkg::TSS_INIT;
                    end
                end
                tss_pkg::TSS_INIT: begin
                    state_r <= tss_pkg::TSS_ARM;
                end
                tss_pkg::TSS_ARM: begin
                    rem_r <= trig_repeat_count_r;
                    if (arm_evt) begin
                        if (trig_src_sel_r == `TSS_SRC_IMM) begin
                            acq_r <= 1'b1;
                        end else begin
                            state_r <= tss_pkg::TSS_TRIG;
                        end
                    end
                end
                tss_pkg::TSS_TRIG: begin
                    if (trig_hit) begin
                        trg_r   <= 1'b1;
                        acc_r   <= 35'h0;
                        state_r <= tss_pkg::TSS_DLY;
                    end
                end
                tss_pkg::TSS_DLY: begin
                    if (acc_r >= tgt) begin
                        acq_r   <= 1'b1;
                        rem_r   <= rem_r - 31'h1;
                        state_r <= last ? tss_pkg::TSS_ARM :
                                          tss_pkg::TSS_TRIG;
                    end else if (smp_tick) begin
                        acc_r <= acc_r + {2'h0, samp_r, 1'b0};
                    end
                end
                default: state_r <= tss_pkg::TSS_IDLE;
            endcase
        end
    end
    assign trig_evt_o  = trg_r;
    assign acq_start_o = acq_r;
    assign state_o     = state_r;

    // checks
    AST_SRC_RANGE: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) trig_src_sel_r <= `TSS_SRC_MAX)
        else $error("source code out of range");
    AST_IMM_SKIP: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) (state_r == tss_pkg::TSS_ARM && arm_evt &&
        trig_src_sel_r == `TSS_SRC_IMM) |=> acq_r &&
        state_r == tss_pkg::TSS_ARM)
        else $error("immediate did not start at once");
    AST_POS_EDGE: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) (state_r == tss_pkg::TSS_TRIG &&
        trig_src_sel_r >= `TSS_SRC_POS0 && trig_src_sel_r < `TSS_SRC_NEG0
        && rise[pos_idx[2:0]]) |=> trg_r ##1 !trg_r)
        else $error("rising edge missed");
    AST_NEG_EDGE: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) (state_r == tss_pkg::TSS_TRIG &&
        trig_src_sel_r >= `TSS_SRC_NEG0 && fall[neg_idx[2:0]])
        |=> trg_r && state_r == tss_pkg::TSS_DLY)
        else $error("falling edge missed");
    AST_LINE_RANGE: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) combined_evt_out_line_r <= `TSS_LINE_NONE &&
        combined_evt_in_line_r <= `TSS_LINE_NONE)
        else $error("line selector out of range");
    AST_OUT_DRIVE: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) $rose(comb_evt_r) && $stable(combined_evt_out_line_r)
        && $stable(bus_cfg_r) |=> (trig_bus_o == (bus_cfg_r &
        (8'h1 << combined_evt_out_line_r))))
        else $error("combined event not driven");
    AST_TMR_EXCL: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) !(pat_r.tmr && arm_tmr_r))
        else $error("timer used as arm and trigger");
    AST_SOFT_ILL: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) cmd_soft && !src_is_pat |=> soft_ill_r && !comb_evt_r)
        else $error("illegal software trigger not flagged");
    AST_INIT: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) state_r == tss_pkg::TSS_IDLE && cmd_init
        |=> state_r == tss_pkg::TSS_INIT ##1 state_r == tss_pkg::TSS_ARM)
        else $error("initiate did not reach init");
    AST_EDGE_PULSE: assert property (@(posedge core_clk_i) disable iff
        (!resetn_i) rise[0] |=> !rise[0] && lvl_r[0])
        else $error("edge pulse longer than one cycle");
endmodule

// [sim/tss_bus_peer.sv]
// peer instruments on the shared trigger bus
module tss_bus_peer (
    // clock
    input  wire logic       clk_i,
    // device drive
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    // peer levels and resolved bus
    input  wire logic [7:0] lvl_i,
    output logic      [7:0] bus_o,
    output int              seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] prev_r = 8'h00;
    initial seen_o = 0;
    // peer yields each line the device enables
    assign bus_o = (oe_i & drv_i) | (~oe_i & lvl_i);
    // one count per driven pulse, however long it stands
    always @(posedge clk_i) begin
        prev_r <= oe_i & drv_i;
        if (|(oe_i & drv_i & ~prev_r)) seen_o <= seen_o + 1;
    end
endmodule

// [sim/tb_top.sv]
// testbench for the trigger source select block
`include "tss_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [7:0]  r;
        logic [31:0] m;
        logic [31:0] e;
    } tss_row_t;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, arm = 1'b0, pos, tev, acq, ack;
    logic [7:0]  adr = 8'h00, lvl = 8'h00, dio = 8'h00, bus, bo, boe;
    logic [31:0] dat = 32'h0, rd, q;
    logic [2:0]  st;
    int          n_fail = 0, cmp_count = 0, n_trig = 0, n_acq = 0;
    int          cyc_n = 0, seen, t0, a0, s0, ln;
    logic        saw_init = 1'b0;
    tss_row_t    rows [13] = '{
        '{0, 8'h00, 0, 8'h00, 32'hffffffff, 32'h0},
        '{0, 8'h10, 0, 8'h10, 32'hffffffff, 32'h808},
        '{0, 8'h14, 0, 8'h14, 32'hffffffff, 32'h1},
        '{0, 8'h08, 0, 8'h08, 32'hffffffff, 32'h0},
        '{1, 8'h00, 32'h12, 8'h00, 32'hffffffff, 32'h0},
        '{1, 8'h00, 32'h11, 8'h00, 32'hffffffff, 32'h11},
        '{1, 8'h04, 32'h1010000, 8'h04, 32'hffffffff, 32'h0},
        '{0, 8'h24, 0, 8'h24, 32'h20, 32'h20},
        '{1, 8'h24, 32'h20, 8'h24, 32'h20, 32'h0},
        '{1, 8'h40, 32'hffffffff, 8'h40, 32'hffffffff, 32'h0},
        '{1, 8'h08, 32'hffffffff, 8'h08, 32'hffffffff, 32'hffffffff},
        '{1, 8'h0c, 32'h9f437c1, 8'h08, 32'hffffffff, 32'hffffffff},
        '{1, 8'h08, 32'h0, 8'h00, 32'hffffffff, 32'h11}};
    always #4 clk = ~clk;
    tss_top #(.SAMP_PERIOD_US(32'h0000_0002)) u_dut (
        .core_clk_i(clk), .resetn_i(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .trig_bus_i(bus), .trig_bus_o(bo), .trig_bus_oe_o(boe),
        .dio_i(dio), .arm_evt_i(arm), .trig_evt_o(tev),
        .acq_start_o(acq), .state_o(st));
    tss_bus_peer u_peer (.clk_i(clk), .drv_i(bo), .oe_i(boe),
        .lvl_i(lvl), .bus_o(bus), .seen_o(seen));
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (tev === 1'b1) n_trig <= n_trig + 1;
        if (acq === 1'b1) n_acq <= n_acq + 1;
        if (st === 3'h1) saw_init <= 1'b1;
        if (cyc_n == 30000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        r = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_st(input logic [2:0] s);
        int n;
        n = 0;
        while (st !== s && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("state", {29'h0, st}, {29'h0, s});
    endtask
    task automatic pulse_arm(input logic [2:0] s);
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
        wait_st(s);
    endtask
    initial begin
        step(20);
        rst_n <= 1'b1;
        step(1);
        chk("oe", {24'h0, boe}, 32'h0);
        chk("state", {29'h0, st}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d, q);
            wb(1'b0, rows[i].r, 32'h0, q);
            chk("reg", q & rows[i].m, rows[i].e);
        end
        $display("test registers done");
        wb(1'b1, `TSS_ADR_CMD, 32'h1, q);
        wait_st(3'h2);
        chk("init", {31'h0, saw_init}, 32'h1);
        for (int c = 2; c < 18; c++) begin
            ln = (c - 2) % 8;
            pos = (c < 10);
            lvl <= {8{pos}};
            step(6);
            wb(1'b1, `TSS_ADR_SRC, 32'(c), q);
            pulse_arm(3'h3);
            t0 = n_trig;
            lvl[ln] <= ~pos;
            step(8);
            chk("wrong edge", n_trig, t0);
            lvl[ln] <= pos;
            step(8);
            chk("edge", n_trig, t0 + 1);
            chk("back to arm", {29'h0, st}, 32'h2);
        end
        $display("test edges done");
        wb(1'b1, `TSS_ADR_SRC, 32'h0, q);
        t0 = n_trig;
        a0 = n_acq;
        pulse_arm(3'h2);
        step(4);
        chk("imm trig", n_trig, t0);
        chk("imm acq", n_acq, a0 + 1);
        wb(1'b1, `TSS_ADR_SRC, 32'h2, q);
        pulse_arm(3'h3);
        wb(1'b1, `TSS_ADR_CMD, 32'h2, q);
        wb(1'b0, `TSS_ADR_STAT, 32'h0, q);
        chk("soft flag", q & 32'h10, 32'h10);
        chk("soft ignored", n_trig, t0);
        wb(1'b1, `TSS_ADR_PAT, 32'h2_0000, q);
        wb(1'b1, `TSS_ADR_SRC, 32'h1, q);
        wb(1'b1, `TSS_ADR_CMD, 32'h2, q);
        wait_st(3'h2);
        chk("soft trig", n_trig, t0 + 1);
        $display("test immediate and soft done");
        wb(1'b1, `TSS_ADR_DELAY, 32'h1, q);
        wb(1'b1, `TSS_ADR_PAT, 32'h100, q);
        wb(1'b1, `TSS_ADR_CMD, 32'h4, q);
        wait_st(3'h3);
        a0 = n_acq;
        t0 = n_trig;
        dio[0] <= 1'b1;
        step(8);
        chk("dio trig", n_trig, t0 + 1);
        chk("dly early", n_acq, a0);
        step(260);
        chk("dly acq", n_acq, a0 + 1);
        wb(1'b1, `TSS_ADR_DELAY, 32'h0, q);
        $display("test delay done");
        wb(1'b1, `TSS_ADR_LINES, 32'h8_0803, q);
        chk("oe", {24'h0, boe}, 32'h8);
        wb(1'b1, `TSS_ADR_PAT, 32'h1, q);
        pulse_arm(3'h3);
        t0 = n_trig;
        s0 = seen;
        lvl[0] <= 1'b1;
        step(10);
        chk("out line", seen, s0 + 1);
        chk("bus trig", n_trig, t0 + 1);
        wb(1'b1, `TSS_ADR_LINES, 32'h8_0503, q);
        pulse_arm(3'h3);
        t0 = n_trig;
        lvl[0] <= 1'b0;
        step(6);
        lvl[0] <= 1'b1;
        step(10);
        chk("in line idle", n_trig, t0);
        lvl[5] <= 1'b1;
        step(10);
        chk("in line", n_trig, t0 + 1);
        wb(1'b1, `TSS_ADR_LINES, 32'h8_0303, q);
        pulse_arm(3'h3);
        t0 = n_trig;
        lvl[0] <= 1'b0;
        step(6);
        lvl[0] <= 1'b1;
        step(16);
        chk("loop back", n_trig, t0 + 1);
        $display("test lines done");
        wb(1'b1, `TSS_ADR_LINES, 32'h808, q);
        wb(1'b1, `TSS_ADR_SETUP, 32'h2, q);
        wb(1'b0, `TSS_ADR_PAT, 32'h0, q);
        chk("setup pat", q, 32'h1_0000);
        wb(1'b0, `TSS_ADR_PER, 32'h0, q);
        chk("setup per", q, 32'h2);
        pulse_arm(3'h3);
        t0 = n_trig;
        step(600);
        chk("timer", n_trig, t0 + 1);
        $display("test timer done");
        rst_n <= 1'b0;
        step(2);
        rst_n <= 1'b1;
        step(1);
        chk("rst state", {29'h0, st}, 32'h0);
        wb(1'b0, `TSS_ADR_SRC, 32'h0, q);
        chk("rst src", q, 32'h0);
        wb(1'b0, `TSS_ADR_PER, 32'h0, q);
        chk("rst per", q, 32'h0);
        $display("test reset done");
        finish_test();
    end
endmodule
